// File: ebtl_pkg.sv
`default_nettype none
package ebtl_pkg;
    localparam int          BP_DEPTH       = 4064;
    localparam logic [11:0] BP_LIMIT_SMALL = 12'h7DF;
    localparam logic [11:0] BP_LIMIT_LARGE = 12'hFDF;
    localparam int          TRACE_DEPTH    = 8192;
    localparam int          TP_W           = 13;
    localparam int          TRACE_W        = 64;
    localparam logic [12:0] TP_MAX         = 13'h1FFF;
    localparam logic [10:0] MON_LO_SMALL   = 11'h780;
    localparam logic [10:0] MON_LO_LARGE   = 11'h700;
    localparam logic [10:0] MON_HI         = 11'h7FF;
    localparam logic [10:0] MON_RESET      = 11'h780;

    localparam logic [7:0] OFS_CTRL       = 8'h00;
    localparam logic [7:0] OFS_MON_ADDR   = 8'h04;
    localparam logic [7:0] OFS_FILL_LO    = 8'h08;
    localparam logic [7:0] OFS_FILL_HI    = 8'h0C;
    localparam logic [7:0] OFS_FILL_CMD   = 8'h10;
    localparam logic [7:0] OFS_BP_ADDR    = 8'h14;
    localparam logic [7:0] OFS_BP_DATA    = 8'h18;
    localparam logic [7:0] OFS_STATUS     = 8'h1C;
    localparam logic [7:0] OFS_BREAK_PC   = 8'h20;
    localparam logic [7:0] OFS_NEXT_PC    = 8'h24;
    localparam logic [7:0] OFS_TRACE_IDX  = 8'h28;
    localparam logic [7:0] OFS_TRACE_LO   = 8'h2C;
    localparam logic [7:0] OFS_TRACE_HI   = 8'h30;
    localparam logic [7:0] OFS_RUN        = 8'h34;

    localparam int CTRL_BP_EN   = 0;
    localparam int CTRL_CYC_EN  = 1;
    localparam int CTRL_TP_EN   = 2;
    localparam int CTRL_LARGE   = 3;
    localparam int CTRL_GRP_LSB = 4;
    localparam int FILL_VAL     = 0;
    localparam int FILL_ALL     = 1;
    localparam int RUN_RESUME   = 0;
    localparam int RUN_TP_CLR   = 1;

    localparam logic [1:0] GRP_BANK   = 2'h0;
    localparam logic [1:0] GRP_P4_P0  = 2'h1;
    localparam logic [1:0] GRP_P4_P1  = 2'h2;

    localparam logic [1:0] CAUSE_NONE = 2'h0;
    localparam logic [1:0] CAUSE_BP   = 2'h1;
    localparam logic [1:0] CAUSE_CYC  = 2'h2;
    localparam logic [1:0] CAUSE_TP   = 2'h3;
endpackage : ebtl_pkg
`default_nettype wire

// File: ebtl_bp_if.sv
`default_nettype none
interface ebtl_bp_if;
    logic        wr_en;
    logic [11:0] wr_addr;
    logic        wr_val;
    logic        fill_start;
    logic [11:0] fill_lo;
    logic [11:0] fill_hi;
    logic        fill_val;
    logic        large_mode;
    logic [11:0] look_addr;
    logic        hit;
    logic [11:0] rd_addr;
    logic        rd_bit;
    logic        busy;
    modport ctl (output wr_en, wr_addr, wr_val, fill_start, fill_lo, fill_hi, fill_val,
                 large_mode, look_addr, rd_addr, input hit, rd_bit, busy);
    modport mem (input wr_en, wr_addr, wr_val, fill_start, fill_lo, fill_hi, fill_val,
                 large_mode, look_addr, rd_addr, output hit, rd_bit, busy);
endinterface : ebtl_bp_if
`default_nettype wire

// File: ebtl_bp_mem.sv
`default_nettype none
module ebtl_bp_mem (
    input  wire logic hclk,
    input  wire logic hresetn,
    ebtl_bp_if.mem    bp
);
    logic [11:0] limit;
    logic [11:0] cur_q;
    logic [11:0] end_q;
    logic        val_q;
    logic        busy_q;
    logic [ebtl_pkg::BP_DEPTH-1:0] bits_q;

    assign limit    = bp.large_mode ? ebtl_pkg::BP_LIMIT_LARGE : ebtl_pkg::BP_LIMIT_SMALL;

    // Fill walks one bit per cycle; the top end is clipped to the mode's area
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cur_q  <= 12'h000;
            end_q  <= 12'h000;
            val_q  <= 1'b0;
            busy_q <= 1'b0;
        end else if (bp.fill_start) begin
            cur_q  <= bp.fill_lo;
            end_q  <= (bp.fill_hi > limit) ? limit : bp.fill_hi;
            val_q  <= bp.fill_val;
            busy_q <= (bp.fill_lo <= bp.fill_hi) && (bp.fill_lo <= limit);
        end else if (busy_q) begin
            if (cur_q == end_q) begin
                busy_q <= 1'b0;
            end else begin
                cur_q <= cur_q + 12'h001;
            end
        end
    end

    // One bit per code address, each written on its own
    for (genvar i = 0; i < ebtl_pkg::BP_DEPTH; i++) begin : g_bit
        always_ff @(posedge hclk or negedge hresetn) begin
            if (!hresetn) begin
                bits_q[i] <= 1'b0;
            end else if (busy_q && cur_q == 12'(i)) begin
                bits_q[i] <= val_q;
            end else if (bp.wr_en && bp.wr_addr == 12'(i) && bp.wr_addr <= limit) begin
                bits_q[i] <= bp.wr_val;
            end
        end
    end

    // Only the first-byte address of each instruction is ever looked up
    assign bp.hit    = (bp.look_addr <= limit) && bits_q[bp.look_addr];
    assign bp.rd_bit = (bp.rd_addr <= limit) && bits_q[bp.rd_addr];
    assign bp.busy   = busy_q;

    AST_OUT_OF_AREA: assert property (@(posedge hclk) disable iff (!hresetn)
        (bp.look_addr > limit) |-> !bp.hit)
        else $error("breakpoint hit outside the bit area");

    AST_FILL_STORES: assert property (@(posedge hclk) disable iff (!hresetn)
        (busy_q && !bp.fill_start) |=> (bits_q[$past(cur_q)] == $past(val_q)))
        else $error("fill did not store its value");
endmodule : ebtl_bp_mem
`default_nettype wire

// File: ebtl_top.sv
`default_nettype none
module ebtl_top (
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic             hresp,
    output logic [31:0]      hrdata,
    input  wire logic        exec_valid,
    input  wire logic [11:0] exec_pc,
    input  wire logic [11:0] exec_next_pc,
    input  wire logic        exec_trace,
    input  wire logic        cycle_count_wrap,
    input  wire logic [3:0]  reg_b,
    input  wire logic [3:0]  reg_a,
    input  wire logic [3:0]  reg_h,
    input  wire logic [3:0]  reg_l,
    input  wire logic        carry_flag,
    input  wire logic [7:0]  stack_pointer_value,
    input  wire logic        ram_wr_valid,
    input  wire logic [10:0] ram_wr_addr,
    input  wire logic [7:0]  ram_wr_data,
    input  wire logic        ram_wr_wide,
    input  wire logic [3:0]  port_two,
    input  wire logic [3:0]  port_three,
    input  wire logic [3:0]  port_four,
    input  wire logic [3:0]  port_zero,
    input  wire logic [3:0]  port_one,
    input  wire logic        bank_common_flag,
    input  wire logic        bank_extra_flag,
    input  wire logic [2:0]  bank_select_low,
    input  wire logic [2:0]  bank_select_high,
    output logic             emu_halt
);
    ebtl_bp_if bp ();

    logic        rd_pend_q;
    logic        wr_pend_q;
    logic [7:0]  addr_q;
    logic        hreadyout_q;
    logic [31:0] hrdata_q;
    logic        bp_en_q;
    logic        cyc_en_q;
    logic        tp_en_q;
    logic        large_q;
    logic [1:0]  grp_q;
    logic [10:0] mon_addr_q;
    logic [11:0] fill_lo_q;
    logic [11:0] fill_hi_q;
    logic        fill_start_q;
    logic        fill_val_q;
    logic [11:0] bp_addr_q;
    logic        bp_wr_q;
    logic        bp_val_q;
    logic [12:0] trace_idx_q;
    localparam int TP_W_L = ebtl_pkg::TP_W;
    logic [TP_W_L-1:0] tp_q;
    logic        wrapped_q;
    logic        halt_q;
    logic [1:0]  cause_q;
    logic [11:0] break_pc_q;
    logic [11:0] next_pc_q;
    logic [12:0] brk_tp_q;
    logic        cyc_pend_q;
    logic [7:0]  mon_data_q;
    logic [ebtl_pkg::TRACE_W-1:0] trace_mem [ebtl_pkg::TRACE_DEPTH];

    logic        wr_acc;
    logic        run;
    logic        trace_wr;
    logic        tp_top;
    logic        grp_chg;
    logic        tp_clr;
    logic        resume;
    logic        bp_brk;
    logic        cyc_brk;
    logic        tp_brk;
    logic [10:0] mon_lo;
    logic [1:0]  grp_w;
    logic [10:0] mon_w;
    logic [7:0]  grp_data;
    logic [63:0] entry;
    logic [63:0] trace_rd;
    logic [31:0] rd_d;

    ebtl_bp_mem u_bp_mem (
        .hclk    (hclk),
        .hresetn (hresetn),
        .bp      (bp.mem)
    );

    assign wr_acc  = wr_pend_q;
    assign grp_w   = hwdata[ebtl_pkg::CTRL_GRP_LSB +: 2];
    assign mon_w   = hwdata[10:0];
    assign mon_lo  = large_q ? ebtl_pkg::MON_LO_LARGE : ebtl_pkg::MON_LO_SMALL;
    assign grp_chg = wr_acc && addr_q == ebtl_pkg::OFS_CTRL && grp_w != 2'h3 && grp_w != grp_q;
    assign tp_clr  = wr_acc && addr_q == ebtl_pkg::OFS_RUN && hwdata[ebtl_pkg::RUN_TP_CLR];
    assign resume  = wr_acc && addr_q == ebtl_pkg::OFS_RUN && hwdata[ebtl_pkg::RUN_RESUME];
    assign run     = !halt_q;
    assign trace_wr = run && exec_valid && exec_trace;
    assign tp_top  = tp_q == ebtl_pkg::TP_MAX;

    // Break sources, looked at when the instruction has completed
    assign bp_brk  = run && exec_valid && bp_en_q && bp.hit;
    assign cyc_brk = run && exec_valid && cyc_en_q && (cyc_pend_q || cycle_count_wrap);
    assign tp_brk  = trace_wr && tp_en_q && tp_top;

    assign bp.wr_en      = bp_wr_q;
    assign bp.wr_addr    = bp_addr_q;
    assign bp.wr_val     = bp_val_q;
    assign bp.fill_start = fill_start_q;
    assign bp.fill_lo    = fill_lo_q;
    assign bp.fill_hi    = fill_hi_q;
    assign bp.fill_val   = fill_val_q;
    assign bp.large_mode = large_q;
    assign bp.look_addr  = exec_pc;
    assign bp.rd_addr    = bp_addr_q;

    always_comb begin
        case (grp_q)
            ebtl_pkg::GRP_P4_P0: grp_data = {port_four, port_zero};
            ebtl_pkg::GRP_P4_P1: grp_data = {port_four, port_one};
            default:             grp_data = {bank_common_flag, bank_select_low, bank_extra_flag, bank_select_high};
        endcase
    end

    assign entry = {15'h0000, grp_data, port_three, port_two, mon_data_q, stack_pointer_value,
                    carry_flag, reg_l, reg_h, reg_a, reg_b};
    assign trace_rd = trace_mem[trace_idx_q];

    // AHB-Lite: writes take no wait state, reads one so the data comes from a flop
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rd_pend_q   <= 1'b0;
            wr_pend_q   <= 1'b0;
            addr_q      <= 8'h00;
            hreadyout_q <= 1'b1;
            hrdata_q    <= 32'h0000_0000;
        end else begin
            if (rd_pend_q) begin
                rd_pend_q   <= 1'b0;
                hreadyout_q <= 1'b1;
                hrdata_q    <= rd_d;
            end else if (hsel && htrans[1] && hready) begin
                rd_pend_q   <= !hwrite;
                hreadyout_q <= hwrite;
                addr_q      <= haddr[7:0];
            end
            wr_pend_q <= hsel && htrans[1] && hready && hwrite && !rd_pend_q;
        end
    end

    always_comb begin
        rd_d = 32'h0000_0000;
        if (addr_q == ebtl_pkg::OFS_CTRL) begin
            rd_d[5:0] = {grp_q, large_q, tp_en_q, cyc_en_q, bp_en_q};
        end else if (addr_q == ebtl_pkg::OFS_MON_ADDR) begin
            rd_d[10:0] = mon_addr_q;
        end else if (addr_q == ebtl_pkg::OFS_FILL_LO) begin
            rd_d[11:0] = fill_lo_q;
        end else if (addr_q == ebtl_pkg::OFS_FILL_HI) begin
            rd_d[11:0] = fill_hi_q;
        end else if (addr_q == ebtl_pkg::OFS_FILL_CMD) begin
            rd_d[0] = bp.busy;
        end else if (addr_q == ebtl_pkg::OFS_BP_ADDR) begin
            rd_d[11:0] = bp_addr_q;
        end else if (addr_q == ebtl_pkg::OFS_BP_DATA) begin
            rd_d[0] = bp.rd_bit;
        end else if (addr_q == ebtl_pkg::OFS_STATUS) begin
            rd_d[29:0] = {brk_tp_q, tp_q, wrapped_q, cause_q, halt_q};
        end else if (addr_q == ebtl_pkg::OFS_BREAK_PC) begin
            rd_d[11:0] = break_pc_q;
        end else if (addr_q == ebtl_pkg::OFS_NEXT_PC) begin
            rd_d[11:0] = next_pc_q;
        end else if (addr_q == ebtl_pkg::OFS_TRACE_IDX) begin
            rd_d[12:0] = trace_idx_q;
        end else if (addr_q == ebtl_pkg::OFS_TRACE_LO) begin
            rd_d = trace_rd[31:0];
        end else if (addr_q == ebtl_pkg::OFS_TRACE_HI) begin
            rd_d = trace_rd[63:32];
        end
    end

    // Configuration written by the console
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            bp_en_q      <= 1'b0;
            cyc_en_q     <= 1'b0;
            tp_en_q      <= 1'b0;
            large_q      <= 1'b0;
            grp_q        <= ebtl_pkg::GRP_BANK;
            mon_addr_q   <= ebtl_pkg::MON_RESET;
            fill_lo_q    <= 12'h000;
            fill_hi_q    <= 12'h000;
            fill_start_q <= 1'b0;
            fill_val_q   <= 1'b0;
            bp_addr_q    <= 12'h000;
            bp_wr_q      <= 1'b0;
            bp_val_q     <= 1'b0;
            trace_idx_q  <= 13'h0000;
        end else begin
            fill_start_q <= 1'b0;
            bp_wr_q      <= 1'b0;
            if (wr_acc && addr_q == ebtl_pkg::OFS_CTRL) begin
                bp_en_q  <= hwdata[ebtl_pkg::CTRL_BP_EN];
                cyc_en_q <= hwdata[ebtl_pkg::CTRL_CYC_EN];
                tp_en_q  <= hwdata[ebtl_pkg::CTRL_TP_EN];
                large_q  <= hwdata[ebtl_pkg::CTRL_LARGE];
                if (grp_w != 2'h3) begin
                    grp_q <= grp_w;
                end
            end
            // Out-of-range addresses are dropped, keeping the old setting
            if (wr_acc && addr_q == ebtl_pkg::OFS_MON_ADDR && mon_w >= mon_lo && mon_w <= ebtl_pkg::MON_HI) begin
                mon_addr_q <= mon_w;
            end
            if (wr_acc && addr_q == ebtl_pkg::OFS_FILL_LO) begin
                fill_lo_q <= hwdata[11:0];
            end
            if (wr_acc && addr_q == ebtl_pkg::OFS_FILL_HI) begin
                fill_hi_q <= hwdata[11:0];
            end
            if (wr_acc && addr_q == ebtl_pkg::OFS_FILL_CMD) begin
                fill_start_q <= 1'b1;
                fill_val_q   <= hwdata[ebtl_pkg::FILL_VAL];
                if (hwdata[ebtl_pkg::FILL_ALL]) begin
                    fill_lo_q <= 12'h000;
                    fill_hi_q <= large_q ? ebtl_pkg::BP_LIMIT_LARGE : ebtl_pkg::BP_LIMIT_SMALL;
                end
            end
            if (wr_acc && addr_q == ebtl_pkg::OFS_BP_ADDR) begin
                bp_addr_q <= hwdata[11:0];
            end
            if (wr_acc && addr_q == ebtl_pkg::OFS_BP_DATA) begin
                bp_wr_q  <= 1'b1;
                bp_val_q <= hwdata[0];
            end
            if (wr_acc && addr_q == ebtl_pkg::OFS_TRACE_IDX) begin
                trace_idx_q <= hwdata[12:0];
            end
        end
    end

    // Monitored RAM location; narrow writes show FH in the upper nibble
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            mon_data_q <= 8'hFF;
        end else if (ram_wr_valid && ram_wr_addr == mon_addr_q) begin
            mon_data_q <= ram_wr_wide ? ram_wr_data : {4'hF, ram_wr_data[3:0]};
        end
    end

    // Trace ring; no reset since only entries below the pointer, or every entry once the wrap flag is set, are meaningful
    always_ff @(posedge hclk) begin
        if (trace_wr) begin
            trace_mem[tp_q] <= entry;
        end
    end

    // Pointer and wrap flag; a wrap in the clearing cycle still sets the flag
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            tp_q      <= 13'h0000;
            wrapped_q <= 1'b0;
        end else begin
            if (grp_chg || tp_clr) begin
                tp_q <= 13'h0000;
            end else if (trace_wr) begin
                tp_q <= tp_q + 13'h0001;
            end
            if (trace_wr && tp_top) begin
                wrapped_q <= 1'b1;
            end else if (grp_chg || tp_clr) begin
                wrapped_q <= 1'b0;
            end
        end
    end

    // Break capture after the instruction completes
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            halt_q     <= 1'b0;
            cause_q    <= ebtl_pkg::CAUSE_NONE;
            break_pc_q <= 12'h000;
            next_pc_q  <= 12'h000;
            brk_tp_q   <= 13'h0000;
            cyc_pend_q <= 1'b0;
        end else begin
            if (cycle_count_wrap && cyc_en_q && !cyc_brk) begin
                cyc_pend_q <= 1'b1;
            end else if (cyc_brk || !cyc_en_q) begin
                cyc_pend_q <= 1'b0;
            end
            if (bp_brk || cyc_brk || tp_brk) begin
                halt_q     <= 1'b1;
                break_pc_q <= exec_pc;
                next_pc_q  <= exec_next_pc;
                brk_tp_q   <= trace_wr ? tp_q + 13'h0001 : tp_q;
                cause_q    <= bp_brk ? ebtl_pkg::CAUSE_BP : cyc_brk ? ebtl_pkg::CAUSE_CYC
                                                                    : ebtl_pkg::CAUSE_TP;
            end else if (resume) begin
                halt_q <= 1'b0;
            end
        end
    end

    assign hreadyout = hreadyout_q;
    assign hresp     = 1'b0;
    assign hrdata    = hrdata_q;
    assign emu_halt  = halt_q;

    AST_BP_BREAK: assert property (@(posedge hclk) disable iff (!hresetn)
        (run && exec_valid && bp_en_q && bp.hit) |=> (halt_q && cause_q == ebtl_pkg::CAUSE_BP
                                                     && break_pc_q == $past(exec_pc)))
        else $error("breakpoint hit did not halt");
    AST_ALL_OFF: assert property (@(posedge hclk) disable iff (!hresetn)
        (!halt_q && !bp_en_q && !cyc_en_q && !tp_en_q) |=> !halt_q)
        else $error("halt with every break source disabled");
    AST_TP_BREAK: assert property (@(posedge hclk) disable iff (!hresetn)
        (tp_brk && !bp_brk && !cyc_brk) |=> (halt_q && cause_q == ebtl_pkg::CAUSE_TP))
        else $error("trace pointer wrap did not halt");
    AST_TP_WRAP: assert property (@(posedge hclk) disable iff (!hresetn)
        (trace_wr && tp_top && !grp_chg && !tp_clr) |=> (tp_q == 13'h0000 && wrapped_q))
        else $error("pointer wrap wrong");
    AST_TP_STEP: assert property (@(posedge hclk) disable iff (!hresetn)
        (trace_wr && !tp_top && !grp_chg && !tp_clr) |=> (tp_q == $past(tp_q) + 13'h0001))
        else $error("pointer did not advance");
    AST_GRP_CLEAR: assert property (@(posedge hclk) disable iff (!hresetn)
        grp_chg |=> (tp_q == 13'h0000))
        else $error("group change kept the pointer");
    AST_MON_WIDE: assert property (@(posedge hclk) disable iff (!hresetn)
        (ram_wr_valid && ram_wr_wide && ram_wr_addr == mon_addr_q) |=> (mon_data_q == $past(ram_wr_data)))
        else $error("monitored data not captured");
    AST_HALT_HOLD: assert property (@(posedge hclk) disable iff (!hresetn)
        (halt_q && !resume) |=> (halt_q && $stable(break_pc_q) && $stable(brk_tp_q)))
        else $error("halt state lost");
endmodule : ebtl_top
`default_nettype wire

// File: ebtl_core_model.sv
`default_nettype none
module ebtl_core_model (
    input  wire logic   hclk,
    output logic        exec_valid,
    output logic [11:0] exec_pc,
    output logic [11:0] exec_next_pc,
    output logic        exec_trace,
    output logic        cycle_count_wrap
);
    timeunit 1ns;
    timeprecision 1ps;
    initial {exec_valid, exec_pc, exec_next_pc, exec_trace, cycle_count_wrap} = '0;
    // Only first-byte addresses are reported
    task automatic step(input logic [11:0] pc, input logic [11:0] npc, input logic trc, input logic cyc);
        exec_pc <= pc;
        exec_next_pc <= npc;
        exec_trace <= trc;
        cycle_count_wrap <= cyc;
        exec_valid <= 1'b1;
        @(posedge hclk);
        // Released PC lines show junk, not the last value; exec_trace keeps its last value
        exec_pc <= ~pc;
        exec_next_pc <= ~npc;
        exec_valid <= 1'b0;
        cycle_count_wrap <= 1'b0;
    endtask : step
endmodule : ebtl_core_model
`default_nettype wire

// File: tb_top.sv
`default_nettype none
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic        hclk, hresetn, hsel, hwrite, hrdy, hresp, halt, ev, tr, cw, rv, rw;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    logic [31:0] haddr, hwdata, hrdata, d;
    logic [11:0] pc, npc;
    logic [10:0] ra;
    logic [7:0]  rdat, g;
    logic [52:0] cs;
    logic [63:0] ex;
    int          num_errors, tests_run;
    ebtl_top ebtl_top_inst (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hrdy), .hreadyout(hrdy), .hresp(hresp),
        .hrdata(hrdata), .exec_valid(ev), .exec_pc(pc), .exec_next_pc(npc), .exec_trace(tr),
        .cycle_count_wrap(cw), .reg_b(cs[3:0]), .reg_a(cs[7:4]), .reg_h(cs[11:8]), .reg_l(cs[15:12]),
        .carry_flag(cs[16]), .stack_pointer_value(cs[24:17]), .ram_wr_valid(rv), .ram_wr_addr(ra),
        .ram_wr_data(rdat), .ram_wr_wide(rw), .port_two(cs[28:25]), .port_three(cs[32:29]),
        .port_four(cs[36:33]), .port_zero(cs[40:37]), .port_one(cs[44:41]), .bank_common_flag(cs[45]),
        .bank_extra_flag(cs[46]), .bank_select_low(cs[49:47]), .bank_select_high(cs[52:50]), .emu_halt(halt));
    ebtl_core_model ebtl_core_model_inst (.hclk(hclk), .exec_valid(ev), .exec_pc(pc), .exec_next_pc(npc),
        .exec_trace(tr), .cycle_count_wrap(cw));
    task automatic complete_run();
        if (num_errors == 0 && tests_run > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : complete_run
    task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
        tests_run++;
        if (s !== e) begin
            num_errors++;
            $display("wrong value %s expected %h seen %h", nm, e, s);
        end
    endtask : chk
    task automatic ahb(input logic [7:0] a, input logic w, input logic [31:0] wd);
        hsel <= 1'b1;
        haddr <= {24'h0, a};
        hwrite <= w;
        htrans <= 2'h2;
        do @(posedge hclk); while (hrdy !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge hclk); while (hrdy !== 1'b1);
        d = hrdata;
    endtask : ahb
    task automatic rc(input string nm, input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
        ahb(a, 1'b0, 32'h0);
        chk(nm, d & m, e);
    endtask : rc
    task automatic st(input logic [11:0] p, input logic [11:0] n, input logic t, input logic c);
        ebtl_core_model_inst.step(p, n, t, c);
        @(posedge hclk);
    endtask : st
    task automatic fill(input logic [31:0] cmd);
        ahb(ebtl_pkg::OFS_FILL_CMD, 1'b1, cmd);
        repeat (2) @(posedge hclk);
        do ahb(ebtl_pkg::OFS_FILL_CMD, 1'b0, 32'h0); while (d[0] !== 1'b0);
    endtask : fill
    initial begin
        hclk = 1'b0;
        forever #5 hclk = ~hclk;
    end
    // Wrap test alone needs about 16400 cycles
    initial begin
        #400000;
        num_errors++;
        complete_run();
    end
    initial begin
        {hresetn, hsel, hwrite, rv, rw, htrans, haddr, hwdata, ra, rdat} = '0;
        hsize = 3'h2;
        cs = {3'h2, 3'h5, 1'b0, 1'b1, 4'hD, 4'hC, 4'h9, 4'h7, 4'h6, 8'h5A, 1'b1, 16'h4321};
        num_errors = 0;
        tests_run = 0;
        repeat (8) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        rc("ctrl", ebtl_pkg::OFS_CTRL, '1, 32'h0);
        rc("unmapped", 8'h3C, '1, 32'h0);
        ahb(ebtl_pkg::OFS_MON_ADDR, 1'b1, 32'h700);
        rc("mon", ebtl_pkg::OFS_MON_ADDR, '1, 32'h780);
        ahb(ebtl_pkg::OFS_BP_ADDR, 1'b1, 32'h7DF);
        ahb(ebtl_pkg::OFS_BP_DATA, 1'b1, 32'h1);
        ahb(ebtl_pkg::OFS_BP_ADDR, 1'b1, 32'h7E0);
        ahb(ebtl_pkg::OFS_BP_DATA, 1'b1, 32'h1);
        rc("bp limit", ebtl_pkg::OFS_BP_DATA, 32'h1, 32'h0);
        ahb(ebtl_pkg::OFS_BP_ADDR, 1'b1, 32'h7DF);
        rc("bp bit", ebtl_pkg::OFS_BP_DATA, 32'h1, 32'h1);
        st(12'h7DF, 12'h000, 1'b0, 1'b0);
        chk("halt off", {31'h0, halt}, 32'h0);
        ahb(ebtl_pkg::OFS_CTRL, 1'b1, 32'h1);
        st(12'h7DE, 12'h7E0, 1'b0, 1'b0);
        chk("halt tail", {31'h0, halt}, 32'h0);
        st(12'h7DF, 12'h000, 1'b0, 1'b0);
        rc("bp cause", ebtl_pkg::OFS_STATUS, 32'hF, 32'h3);
        rc("brk pc", ebtl_pkg::OFS_BREAK_PC, 32'hFFF, 32'h7DF);
        rc("next pc", ebtl_pkg::OFS_NEXT_PC, 32'hFFF, 32'h0);
        ahb(ebtl_pkg::OFS_RUN, 1'b1, 32'h1);
        ahb(ebtl_pkg::OFS_CTRL, 1'b1, 32'h2);
        st(12'h010, 12'h011, 1'b0, 1'b1);
        rc("cyc cause", ebtl_pkg::OFS_STATUS, 32'hF, 32'h5);
        ahb(ebtl_pkg::OFS_RUN, 1'b1, 32'h1);
        ahb(ebtl_pkg::OFS_FILL_LO, 1'b1, 32'h40);
        ahb(ebtl_pkg::OFS_FILL_HI, 1'b1, 32'h55);
        fill(32'h1);
        ahb(ebtl_pkg::OFS_BP_ADDR, 1'b1, 32'h55);
        rc("fill end", ebtl_pkg::OFS_BP_DATA, 32'h1, 32'h1);
        ahb(ebtl_pkg::OFS_BP_ADDR, 1'b1, 32'h56);
        rc("fill past", ebtl_pkg::OFS_BP_DATA, 32'h1, 32'h0);
        fill(32'h2);
        ahb(ebtl_pkg::OFS_BP_ADDR, 1'b1, 32'h40);
        rc("fill all", ebtl_pkg::OFS_BP_DATA, 32'h1, 32'h0);
        ahb(ebtl_pkg::OFS_MON_ADDR, 1'b1, 32'h7A0);
        rv <= 1'b1;
        rw <= 1'b1;
        ra <= 11'h7A0;
        rdat <= 8'hA5;
        @(posedge hclk);
        ra <= 11'h7A1;
        rdat <= 8'h00;
        @(posedge hclk);
        rv <= 1'b0;
        for (int i = 1; i < 4; i++) begin
            ahb(ebtl_pkg::OFS_CTRL, 1'b1, {26'h0, 2'(i % 3), 4'h0});
            st(12'h020, 12'h021, 1'b1, 1'b0);
            rc("tp", ebtl_pkg::OFS_STATUS, 32'h1FFF0, 32'h10);
            ahb(ebtl_pkg::OFS_TRACE_IDX, 1'b1, 32'h0);
            g = (i % 3 == 0) ? 8'hD2 : ((i % 3 == 1) ? 8'h9C : 8'h9D);
            ex = {15'h0, g, 4'h7, 4'h6, 8'hA5, 8'h5A, 1'b1, 16'h4321};
            rc("trc lo", ebtl_pkg::OFS_TRACE_LO, '1, ex[31:0]);
            rc("trc hi", ebtl_pkg::OFS_TRACE_HI, '1, ex[63:32]);
        end
        ahb(ebtl_pkg::OFS_CTRL, 1'b1, 32'h38);
        rc("ctrl large", ebtl_pkg::OFS_CTRL, '1, 32'h8);
        ahb(ebtl_pkg::OFS_BP_ADDR, 1'b1, 32'h7E0);
        rc("bp refused", ebtl_pkg::OFS_BP_DATA, 32'h1, 32'h0);
        ahb(ebtl_pkg::OFS_BP_ADDR, 1'b1, 32'hFDF);
        ahb(ebtl_pkg::OFS_BP_DATA, 1'b1, 32'h1);
        rc("bp top", ebtl_pkg::OFS_BP_DATA, 32'h1, 32'h1);
        ahb(ebtl_pkg::OFS_MON_ADDR, 1'b1, 32'h700);
        rc("mon large", ebtl_pkg::OFS_MON_ADDR, '1, 32'h700);
        rv <= 1'b1;
        rw <= 1'b0;
        ra <= 11'h700;
        rdat <= 8'h3C;
        @(posedge hclk);
        rv <= 1'b0;
        st(12'h020, 12'h021, 1'b1, 1'b0);
        ahb(ebtl_pkg::OFS_TRACE_IDX, 1'b1, 32'h1);
        rc("ram narrow", ebtl_pkg::OFS_TRACE_LO, 32'hFE00_0000, 32'hF800_0000);
        ahb(ebtl_pkg::OFS_CTRL, 1'b1, 32'h4);
        ahb(ebtl_pkg::OFS_RUN, 1'b1, 32'h2);
        repeat (8192) st(12'h030, 12'h031, 1'b1, 1'b0);
        rc("wrap", ebtl_pkg::OFS_STATUS, '1, 32'hF);
        chk("resp", {31'h0, hresp}, 32'h0);
        complete_run();
    end
endmodule : tb_top
`default_nettype wire
